// *** design/speed_limit_preset_select.sv ***
// speed limit in force control and contact-selected preset speeds
// What this block does
// R01 - raise speed_limit_active_out while limiting acts, if allocated to a terminal
// R02 - source field 0 uses internal limit parameter; latched at restart
// R03 - source field 1 derives limit from analog input scaled by gain
// R04 - internal limit 0..10000 mm/s, default 10000, immediate
// R05 - clamp select: min with motor max or overspeed speed; latched at restart
// R06 - internal limit above motor max is replaced by motor max
// R07 - external limit is further bounded by internal limit parameter
// R08 - gain 150..3000 in 0.01 V per rated speed, default 600; sign ignored
// R09 - over the limit, force is reduced in proportion to the excess speed
// R10 - direction contact, default or alternate input, picks forward or reverse
// R11 - two speed-select contacts, default or alternate, pick the preset
// R12 - control mode field 3 enables preset-speed control; latched at restart
// R13 - three presets 0..10000 mm/s, defaults 10, 20, 30, immediate
// R14 - preset above motor max runs at motor max
// R15 - selects off gives zero; b only 1, both 2, a only 3; direction on reverse
// R16 - combined modes 4..6 allow a mode switch only with both selects off
// R17 - contacts pass two flip-flops and are on when low
`timescale 1ns/100ps
module speed_limit_preset_select #(
    parameter int SPEED_W = speed_limit_pkg::SPEED_W,
    parameter int ADC_W = speed_limit_pkg::ADC_W,
    parameter int FORCE_W = speed_limit_pkg::FORCE_W,
    parameter int RATED_SPEED = 5000,
    parameter int DROOP_SHIFT = 2
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    input wire logic direction_select_in_n,
    input wire logic alt_direction_select_in_n,
    input wire logic speed_select_a_in_n,
    input wire logic alt_speed_select_a_in_n,
    input wire logic speed_select_b_in_n,
    input wire logic alt_speed_select_b_in_n,
    input wire logic signed [ADC_W-1:0] speed_ref_adc,
    input wire logic signed [SPEED_W:0] motor_speed,
    input wire logic signed [FORCE_W-1:0] force_ref_in,
    input wire logic mode_switch_req,
    output logic signed [FORCE_W-1:0] force_ref_out,
    output logic speed_limit_active_out,
    output logic signed [SPEED_W:0] preset_speed_cmd,
    output logic preset_mode_active,
    output logic mode_switch_allowed,
    output logic irq
);
    localparam int IW = speed_limit_pkg::IRQ_W;
    localparam int GW = speed_limit_pkg::GAIN_W;

    // parameter registers
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [SPEED_W-1:0] int_limit_r, int_limit_nxt;
    logic [GW-1:0] gain_r, gain_nxt;
    logic [SPEED_W-1:0] preset_r [3], preset_nxt [3];
    logic [SPEED_W-1:0] motor_max_r, motor_max_nxt;
    logic [SPEED_W-1:0] overspeed_r, overspeed_nxt;

    logic src_act_r, src_act_nxt;
    logic clamp_act_r, clamp_act_nxt;
    logic [3:0] mode_act_r, mode_act_nxt;

    logic [IW-1:0] irq_stat_r, irq_stat_nxt;
    logic [IW-1:0] irq_mask_r, irq_mask_nxt;
    logic [15:0] rdata_r, rdata_nxt;

    // contact synchronisers
    logic [5:0] sync1_r, sync2_r;

    // datapath registers
    logic signed [FORCE_W-1:0] force_r, force_nxt;
    logic limiting_r, limiting_nxt;
    logic signed [SPEED_W:0] cmd_r, cmd_nxt;
    logic [1:0] code_d_r, code_d_nxt;

    contact_if cif ();

    contact_decoder u_dec (
        .cif(cif.decode_side)
    );

    // two flip-flops on every contact; low level means closed
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= ~{direction_select_in_n, alt_direction_select_in_n, speed_select_a_in_n,
                alt_speed_select_a_in_n, speed_select_b_in_n, alt_speed_select_b_in_n}; // R17
            sync2_r <= sync1_r; // R17
        end
    end

    logic use_alt;
    assign use_alt = ctrl_r[speed_limit_pkg::CTRL_ALT_IN_BIT];
    assign cif.dir_on = use_alt ? sync2_r[4] : sync2_r[5]; // R10
    assign cif.sel_a_on = use_alt ? sync2_r[2] : sync2_r[3]; // R11
    assign cif.sel_b_on = use_alt ? sync2_r[0] : sync2_r[1]; // R11

    function automatic logic [SPEED_W-1:0] min_s(input logic [SPEED_W-1:0] a,
        input logic [SPEED_W-1:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [SPEED_W-1:0] sat_speed(input logic [15:0] v);
        return (v > 16'(speed_limit_pkg::SPEED_MAX_SET))
            ? speed_limit_pkg::SPEED_MAX_SET : v[SPEED_W-1:0];
    endfunction

    // external limit: |adc| mV / (gain * 10 mV) * rated speed
    logic [ADC_W-1:0] adc_abs;
    logic [ADC_W+31:0] ext_num;
    logic [ADC_W+31:0] ext_raw;
    logic [SPEED_W-1:0] ext_limit, int_eff, eff_limit, clamp_val;
    always_comb begin
        adc_abs = speed_ref_adc[ADC_W-1]
            ? ADC_W'(-speed_ref_adc) : ADC_W'(speed_ref_adc); // R08
        ext_num = (ADC_W+32)'(adc_abs) * (ADC_W+32)'(RATED_SPEED); // R03
        ext_raw = ext_num
            / ((ADC_W+32)'(gain_r) * (ADC_W+32)'(speed_limit_pkg::ADC_MV_PER_GAIN_UNIT)); // R03
        ext_limit = (ext_raw > (ADC_W+32)'(speed_limit_pkg::SPEED_MAX_SET))
            ? speed_limit_pkg::SPEED_MAX_SET : ext_raw[SPEED_W-1:0];

        clamp_val = (clamp_act_r == speed_limit_pkg::CLAMP_OVERSPEED) ? overspeed_r : motor_max_r; // R05
        int_eff = min_s(min_s(int_limit_r, motor_max_r), clamp_val); // R06
        eff_limit = (src_act_r == speed_limit_pkg::LIMIT_SRC_EXTERNAL)
            ? min_s(ext_limit, int_eff) : int_eff; // R07
    end

    // force droop proportional to excess speed
    logic [SPEED_W:0] spd_abs;
    logic [SPEED_W:0] excess;
    logic signed [FORCE_W+1:0] droop, adj;
    always_comb begin
        spd_abs = motor_speed[SPEED_W] ? (SPEED_W+1)'(-motor_speed) : (SPEED_W+1)'(motor_speed);
        excess = (spd_abs > {1'b0, eff_limit}) ? spd_abs - {1'b0, eff_limit} : '0;
        droop = (FORCE_W+2)'(excess << DROOP_SHIFT);

        if (motor_speed[SPEED_W])
            adj = (FORCE_W+2)'(force_ref_in) + droop; // R09
        else
            adj = (FORCE_W+2)'(force_ref_in) - droop; // R09
        force_nxt = (adj > (FORCE_W+2)'(2**(FORCE_W-1)-1)) ? FORCE_W'(2**(FORCE_W-1)-1)
            : (adj < -(FORCE_W+2)'(2**(FORCE_W-1))) ? FORCE_W'(-(2**(FORCE_W-1))) : FORCE_W'(adj);

        limiting_nxt = (excess != '0); // R01
    end

    // preset selection
    logic preset_mode;
    logic [SPEED_W-1:0] pre_sel;
    always_comb begin
        preset_mode = (mode_act_r == speed_limit_pkg::MODE_PRESET) // R12
            || (mode_act_r == speed_limit_pkg::MODE_PRESET_SPEED)
            || (mode_act_r == speed_limit_pkg::MODE_PRESET_POS)
            || (mode_act_r == speed_limit_pkg::MODE_PRESET_FORCE);

        case (cif.sel_code)
            speed_limit_pkg::SEL_ONE: pre_sel = min_s(preset_r[0], motor_max_r); // R14
            speed_limit_pkg::SEL_TWO: pre_sel = min_s(preset_r[1], motor_max_r); // R14
            speed_limit_pkg::SEL_THREE: pre_sel = min_s(preset_r[2], motor_max_r); // R14
            default: pre_sel = '0; // R15
        endcase

        if (!preset_mode)
            cmd_nxt = '0;
        else if (cif.reverse)
            cmd_nxt = -$signed({1'b0, pre_sel}); // R10
        else
            cmd_nxt = $signed({1'b0, pre_sel}); // R11

        code_d_nxt = cif.sel_code;
    end

    // register file: writes, restart latch, sticky interrupts, read data
    logic wr_hit_stat;
    always_comb begin
        ctrl_nxt = ctrl_r;
        int_limit_nxt = int_limit_r;
        gain_nxt = gain_r;
        preset_nxt = preset_r;
        motor_max_nxt = motor_max_r;
        overspeed_nxt = overspeed_r;
        irq_mask_nxt = irq_mask_r;
        src_act_nxt = src_act_r;
        clamp_act_nxt = clamp_act_r;
        mode_act_nxt = mode_act_r;
        irq_stat_nxt = irq_stat_r;

        wr_hit_stat = wr_stb && (addr == speed_limit_pkg::ADDR_IRQ_STAT);
        if (wr_stb) begin
            case (addr)
                speed_limit_pkg::ADDR_CTRL: ctrl_nxt = wdata[7:0];
                speed_limit_pkg::ADDR_INT_LIMIT: int_limit_nxt = sat_speed(wdata); // R04
                speed_limit_pkg::ADDR_GAIN: begin
                    gain_nxt = (wdata[GW-1:0] < speed_limit_pkg::GAIN_MIN || wdata[15:GW] != '0)
                        ? ((wdata[15:GW] != '0) ? speed_limit_pkg::GAIN_MAX : speed_limit_pkg::GAIN_MIN)
                        : ((wdata[GW-1:0] > speed_limit_pkg::GAIN_MAX) ? speed_limit_pkg::GAIN_MAX
                        : wdata[GW-1:0]); // R08
                end
                speed_limit_pkg::ADDR_PRESET1: preset_nxt[0] = sat_speed(wdata); // R13
                speed_limit_pkg::ADDR_PRESET2: preset_nxt[1] = sat_speed(wdata); // R13
                speed_limit_pkg::ADDR_PRESET3: preset_nxt[2] = sat_speed(wdata); // R13
                speed_limit_pkg::ADDR_MOTOR_MAX: motor_max_nxt = sat_speed(wdata);
                speed_limit_pkg::ADDR_OVERSPEED: overspeed_nxt = sat_speed(wdata);
                speed_limit_pkg::ADDR_IRQ_MASK: irq_mask_nxt = wdata[IW-1:0];
                speed_limit_pkg::ADDR_RESTART: begin
                    src_act_nxt = ctrl_r[speed_limit_pkg::CTRL_SRC_BIT]; // R02
                    clamp_act_nxt = ctrl_r[speed_limit_pkg::CTRL_CLAMP_BIT]; // R05
                    mode_act_nxt =
                        ctrl_r[speed_limit_pkg::CTRL_MODE_LSB +: speed_limit_pkg::CTRL_MODE_W]; // R12
                end
                default: ;
            endcase
        end

        if (wr_hit_stat)
            irq_stat_nxt = irq_stat_r & ~wdata[IW-1:0];
        // set wins over the clear
        if (limiting_nxt && !limiting_r)
            irq_stat_nxt[speed_limit_pkg::IRQ_LIMIT_ON] = 1'b1;
        if (!limiting_nxt && limiting_r)
            irq_stat_nxt[speed_limit_pkg::IRQ_LIMIT_OFF] = 1'b1;
        if (preset_mode && code_d_r != cif.sel_code)
            irq_stat_nxt[speed_limit_pkg::IRQ_SEL_CHANGE] = 1'b1;

        rdata_nxt = 16'h0000;
        if (rd_stb) begin
            case (addr)
                speed_limit_pkg::ADDR_CTRL: rdata_nxt = {8'h00, ctrl_r};
                speed_limit_pkg::ADDR_INT_LIMIT: rdata_nxt = 16'(int_limit_r);
                speed_limit_pkg::ADDR_GAIN: rdata_nxt = 16'(gain_r);
                speed_limit_pkg::ADDR_PRESET1: rdata_nxt = 16'(preset_r[0]);
                speed_limit_pkg::ADDR_PRESET2: rdata_nxt = 16'(preset_r[1]);
                speed_limit_pkg::ADDR_PRESET3: rdata_nxt = 16'(preset_r[2]);
                speed_limit_pkg::ADDR_MOTOR_MAX: rdata_nxt = 16'(motor_max_r);
                speed_limit_pkg::ADDR_OVERSPEED: rdata_nxt = 16'(overspeed_r);
                speed_limit_pkg::ADDR_STATUS: rdata_nxt = {7'h00, mode_act_r, clamp_act_r, src_act_r,
                    cif.sel_idle, cif.reverse, limiting_r};
                speed_limit_pkg::ADDR_IRQ_STAT: rdata_nxt = 16'(irq_stat_r);
                speed_limit_pkg::ADDR_IRQ_MASK: rdata_nxt = 16'(irq_mask_r);
                speed_limit_pkg::ADDR_SPEED_OUT: rdata_nxt = 16'(cmd_r);
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= speed_limit_pkg::CTRL_RST;
            int_limit_r <= speed_limit_pkg::INT_LIMIT_RST;
            gain_r <= speed_limit_pkg::GAIN_RST;
            preset_r[0] <= speed_limit_pkg::PRESET1_RST;
            preset_r[1] <= speed_limit_pkg::PRESET2_RST;
            preset_r[2] <= speed_limit_pkg::PRESET3_RST;
            motor_max_r <= speed_limit_pkg::MOTOR_MAX_RST;
            overspeed_r <= speed_limit_pkg::OVERSPEED_RST;
            src_act_r <= speed_limit_pkg::LIMIT_SRC_INTERNAL;
            clamp_act_r <= speed_limit_pkg::CLAMP_MOTOR_MAX;
            mode_act_r <= 4'h0;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            rdata_r <= 16'h0000;
            force_r <= '0;
            limiting_r <= 1'b0;
            cmd_r <= '0;
            code_d_r <= 2'b00;
        end else begin
            ctrl_r <= ctrl_nxt;
            int_limit_r <= int_limit_nxt;
            gain_r <= gain_nxt;
            preset_r <= preset_nxt;
            motor_max_r <= motor_max_nxt;
            overspeed_r <= overspeed_nxt;
            src_act_r <= src_act_nxt;
            clamp_act_r <= clamp_act_nxt;
            mode_act_r <= mode_act_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            rdata_r <= rdata_nxt;
            force_r <= force_nxt;
            limiting_r <= limiting_nxt;
            cmd_r <= cmd_nxt;
            code_d_r <= code_d_nxt;
        end
    end

    logic combined_mode;
    assign combined_mode = (mode_act_r == speed_limit_pkg::MODE_PRESET_SPEED)
        || (mode_act_r == speed_limit_pkg::MODE_PRESET_POS)
        || (mode_act_r == speed_limit_pkg::MODE_PRESET_FORCE);
    assign mode_switch_allowed = combined_mode && mode_switch_req && cif.sel_idle; // R16
    assign rdata = rdata_r;
    assign force_ref_out = force_r;
    assign speed_limit_active_out = limiting_r
        && ctrl_r[speed_limit_pkg::CTRL_OUT_ALLOC_BIT]; // R01
    assign preset_speed_cmd = cmd_r;
    assign preset_mode_active = preset_mode;
    assign irq = |(irq_stat_r & irq_mask_r);
endmodule

// *** pkg/speed_limit_pkg.sv ***
// package with parameter layouts, defaults and encodings of the speed limit / preset block
package speed_limit_pkg;
    localparam int SPEED_W = 14;
    localparam int GAIN_W = 12;
    localparam int ADC_W = 16;
    localparam int FORCE_W = 16;
    // register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_INT_LIMIT = 4'h1;
    localparam logic [3:0] ADDR_GAIN = 4'h2;
    localparam logic [3:0] ADDR_PRESET1 = 4'h3;
    localparam logic [3:0] ADDR_PRESET2 = 4'h4;
    localparam logic [3:0] ADDR_PRESET3 = 4'h5;
    localparam logic [3:0] ADDR_MOTOR_MAX = 4'h6;
    localparam logic [3:0] ADDR_OVERSPEED = 4'h7;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h9;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'ha;
    localparam logic [3:0] ADDR_SPEED_OUT = 4'hb;
    localparam logic [3:0] ADDR_RESTART = 4'hc;
    // control register fields
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_CLAMP_BIT = 1;
    localparam int CTRL_ALT_IN_BIT = 2;
    localparam int CTRL_OUT_ALLOC_BIT = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_MODE_W = 4;
    // limit source and clamp encodings
    localparam logic LIMIT_SRC_INTERNAL = 1'b0;
    localparam logic LIMIT_SRC_EXTERNAL = 1'b1;
    localparam logic CLAMP_MOTOR_MAX = 1'b0;
    localparam logic CLAMP_OVERSPEED = 1'b1;
    // control modes
    localparam logic [3:0] MODE_PRESET = 4'h3;
    localparam logic [3:0] MODE_PRESET_SPEED = 4'h4;
    localparam logic [3:0] MODE_PRESET_POS = 4'h5;
    localparam logic [3:0] MODE_PRESET_FORCE = 4'h6;
    // reset values and setting range limits
    localparam logic [SPEED_W-1:0] INT_LIMIT_RST = 14'h2710;
    localparam logic [GAIN_W-1:0] GAIN_RST = 12'h258;
    localparam logic [SPEED_W-1:0] PRESET1_RST = 14'h000a;
    localparam logic [SPEED_W-1:0] PRESET2_RST = 14'h0014;
    localparam logic [SPEED_W-1:0] PRESET3_RST = 14'h001e;
    localparam logic [SPEED_W-1:0] SPEED_MAX_SET = 14'h2710;
    localparam logic [GAIN_W-1:0] GAIN_MIN = 12'h096;
    localparam logic [GAIN_W-1:0] GAIN_MAX = 12'hbb8;
    localparam logic [SPEED_W-1:0] MOTOR_MAX_RST = 14'h2710;
    localparam logic [SPEED_W-1:0] OVERSPEED_RST = 14'h2710;
    localparam logic [7:0] CTRL_RST = 8'h08;
    // interrupt status bits
    localparam int IRQ_LIMIT_ON = 0;
    localparam int IRQ_LIMIT_OFF = 1;
    localparam int IRQ_SEL_CHANGE = 2;
    localparam int IRQ_W = 3;
    // speed select decode
    localparam logic [1:0] SEL_ZERO = 2'b00;
    localparam logic [1:0] SEL_ONE = 2'b01;
    localparam logic [1:0] SEL_TWO = 2'b11;
    localparam logic [1:0] SEL_THREE = 2'b10;
    // millivolts per gain unit: 1 count = 1 mV, gain in 10 mV per rated speed
    localparam int ADC_MV_PER_GAIN_UNIT = 10;
endpackage

// *** pkg/contact_if.sv ***
// interface carrying synchronised contact selections between top and decoder
`timescale 1ns/100ps
interface contact_if;
    logic dir_on;
    logic sel_a_on;
    logic sel_b_on;
    logic [1:0] sel_code;
    logic reverse;
    logic sel_idle;
    modport sync_side (output dir_on, output sel_a_on, output sel_b_on, input sel_code, input reverse,
        input sel_idle);
    modport decode_side (input dir_on, input sel_a_on, input sel_b_on, output sel_code, output reverse,
        output sel_idle);
endinterface

// *** design/contact_decoder.sv ***
// decodes speed-select and direction contacts into a preset code and direction
`timescale 1ns/100ps
module contact_decoder (
    contact_if.decode_side cif
);
    always_comb begin
        // second contact alone picks preset 1, both preset 2, first alone preset 3
        cif.sel_code = {cif.sel_a_on, cif.sel_b_on}; // R15
        cif.reverse = cif.dir_on; // R15
        cif.sel_idle = !cif.sel_a_on && !cif.sel_b_on; // R16
    end
endmodule

// *** bench/speed_limit_preset_select_checker.sv ***
// port assertions for the speed limit and preset block
`timescale 1ns/100ps
module speed_limit_preset_select_checker #(
    parameter int SPEED_W = 14,
    parameter int ADC_W = 16,
    parameter int FORCE_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [15:0] rdata,
    input wire logic speed_select_a_in_n,
    input wire logic alt_speed_select_a_in_n,
    input wire logic speed_select_b_in_n,
    input wire logic alt_speed_select_b_in_n,
    input wire logic signed [SPEED_W:0] motor_speed,
    input wire logic signed [FORCE_W-1:0] force_ref_in,
    input wire logic mode_switch_req,
    input wire logic signed [FORCE_W-1:0] force_ref_out,
    input wire logic speed_limit_active_out,
    input wire logic signed [SPEED_W:0] preset_speed_cmd,
    input wire logic preset_mode_active,
    input wire logic mode_switch_allowed,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_rdata_idle; !rd_stb |=> rdata == 16'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");
    property p_unmapped; rd_stb && addr > speed_limit_pkg::ADDR_RESTART |=> rdata == 16'h0; endproperty
    a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned data");
    property p_mask_off; wr_stb && addr == speed_limit_pkg::ADDR_IRQ_MASK && wdata[2:0] == 3'h0 |=> !irq; endproperty
    a_mask_off: assert property (p_mask_off)
    else $error("interrupt high with all sources masked");
    property p_switch_req; mode_switch_allowed |-> mode_switch_req && preset_mode_active; endproperty
    a_switch_req: assert property (p_switch_req)
    else $error("mode switch allowed without request or preset mode");
    property p_switch_sel; mode_switch_allowed |-> $past(speed_select_a_in_n || alt_speed_select_a_in_n, 2)
        && $past(speed_select_b_in_n || alt_speed_select_b_in_n, 2); endproperty
    a_switch_sel: assert property (p_switch_sel)
    else $error("mode switch allowed with a select on");
    property p_sel_off;
        (speed_select_a_in_n && speed_select_b_in_n && alt_speed_select_a_in_n && alt_speed_select_b_in_n) [*3]
        |=> preset_speed_cmd == 0;
    endproperty
    a_sel_off: assert property (p_sel_off)
    else $error("nonzero preset command with selects off");
    property p_mode_off; !preset_mode_active && $past(!preset_mode_active) |-> preset_speed_cmd == 0; endproperty
    a_mode_off: assert property (p_mode_off)
    else $error("preset command outside preset mode");
    property p_still; motor_speed == 0 |=> !speed_limit_active_out && force_ref_out == $past(force_ref_in); endproperty
    a_still: assert property (p_still)
    else $error("limiting at zero speed");
    property p_droop;
        speed_limit_active_out && $past(motor_speed) > 0 && $past(force_ref_in) > 0
        |-> force_ref_out < $past(force_ref_in);
    endproperty
    a_droop: assert property (p_droop)
    else $error("force not reduced while limiting");
endmodule
bind speed_limit_preset_select speed_limit_preset_select_checker #(
    .SPEED_W(SPEED_W), .ADC_W(ADC_W), .FORCE_W(FORCE_W)) i_chk (.*);

// *** bench/host_contact_model.sv ***
// host controller model that closes the contact inputs
`timescale 1ns/100ps
module host_contact_model (
    input wire logic use_alt,
    input wire logic reverse,
    input wire logic [1:0] code,
    output logic direction_select_in_n,
    output logic alt_direction_select_in_n,
    output logic speed_select_a_in_n,
    output logic alt_speed_select_a_in_n,
    output logic speed_select_b_in_n,
    output logic alt_speed_select_b_in_n
);
    // a closed contact pulls low, an unused terminal stays open (high)
    always_comb begin
        direction_select_in_n = use_alt | !reverse;
        alt_direction_select_in_n = !use_alt | !reverse;
        speed_select_a_in_n = use_alt | !code[1];
        alt_speed_select_a_in_n = !use_alt | !code[1];
        speed_select_b_in_n = use_alt | !code[0];
        alt_speed_select_b_in_n = !use_alt | !code[0];
    end
endmodule

// *** bench/tb_speed_limit_preset_select.sv ***
// self-checking bench for the speed limit and preset block
`timescale 1ns/100ps
module tb_speed_limit_preset_select;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [15:0] rdata, rv;
    logic direction_select_in_n, alt_direction_select_in_n, speed_select_a_in_n, alt_speed_select_a_in_n;
    logic speed_select_b_in_n, alt_speed_select_b_in_n, speed_limit_active_out, preset_mode_active;
    logic signed [15:0] speed_ref_adc = 16'sh0;
    logic signed [14:0] motor_speed = 15'sh0;
    logic signed [15:0] force_ref_in = 16'sh0;
    logic signed [15:0] force_ref_out;
    logic signed [14:0] preset_speed_cmd;
    logic mode_switch_req = 1'b0;
    logic mode_switch_allowed, irq;
    logic use_alt = 1'b0;
    logic reverse = 1'b0;
    logic alloc = 1'b1;
    logic [1:0] code = 2'h0;
    logic [15:0] dflt [8] = '{16'h8, 16'h2710, 16'h258, 16'ha, 16'h14, 16'h1e, 16'h2710, 16'h2710};
    int err_total = 0, checks_done = 0, cycles = 0, lim, e, f, g;
    int presets [3];
    speed_limit_preset_select i_dut (.*);
    host_contact_model i_host (.*);
    always #12.5 sys_clk = ~sys_clk;
    task automatic give_verdict();
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 rv = rdata;
    endtask
    function automatic int exp_force(int fin, int spd, int l);
        int x;
        x = (spd < 0 ? -spd : spd) - l;
        if (x <= 0) return fin;
        x = spd > 0 ? fin - 4 * x : fin + 4 * x;
        return x > 32767 ? 32767 : (x < -32768 ? -32768 : x);
    endfunction
    task automatic limit_case(input int spd, input int fin, input int l);
        @(posedge sys_clk);
        motor_speed <= spd[14:0];
        force_ref_in <= fin[15:0];
        @(posedge sys_clk);
        #1 chk(force_ref_out, exp_force(fin, spd, l));
        chk(speed_limit_active_out, alloc && (spd < 0 ? -spd : spd) > l);
    endtask
    task automatic preset_case(input logic rev, input logic [1:0] c);
        int ex;
        ex = c == 2'b01 ? presets[0] : c == 2'b11 ? presets[1] : c == 2'b10 ? presets[2] : 0;
        if (ex > 3000) ex = 3000;
        @(posedge sys_clk);
        reverse <= rev;
        code <= c;
        repeat (4) @(posedge sys_clk);
        #1 chk(preset_speed_cmd, rev ? -ex : ex);
    endtask
    initial begin
        void'($urandom(90));
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        foreach (dflt[i]) begin
            rd(4'(i));
            chk(rv, dflt[i]);
        end
        rd(4'hf);
        chk(rv, 16'h0);
        wr(speed_limit_pkg::ADDR_GAIN, 16'd100);
        rd(speed_limit_pkg::ADDR_GAIN);
        chk(rv, 16'h96);
        repeat (6) begin
            lim = $urandom_range(10000);
            e = $urandom_range(200);
            wr(speed_limit_pkg::ADDR_INT_LIMIT, lim[15:0]);
            limit_case(lim + e, 1000, lim);
            limit_case(-(lim + e), -1000, lim);
        end
        wr(speed_limit_pkg::ADDR_INT_LIMIT, 16'h0);
        limit_case(16000, -32000, 0);
        limit_case(-16000, 32000, 0);
        wr(speed_limit_pkg::ADDR_MOTOR_MAX, 16'd3000);
        wr(speed_limit_pkg::ADDR_INT_LIMIT, 16'd8000);
        limit_case(3100, 2000, 3000);
        wr(speed_limit_pkg::ADDR_OVERSPEED, 16'd2000);
        wr(speed_limit_pkg::ADDR_CTRL, 16'h0a);
        limit_case(2100, 2000, 3000);
        wr(speed_limit_pkg::ADDR_RESTART, 16'h1);
        limit_case(2100, 2000, 2000);
        wr(speed_limit_pkg::ADDR_CTRL, 16'h09);
        wr(speed_limit_pkg::ADDR_RESTART, 16'h1);
        repeat (6) begin
            g = $urandom_range(3000, 150);
            f = $urandom_range(12000);
            wr(speed_limit_pkg::ADDR_GAIN, g[15:0]);
            speed_ref_adc <= $urandom_range(1) ? -f[15:0] : f[15:0];
            lim = f * 5000 / (g * 10);
            if (lim > 3000) lim = 3000;
            repeat (3) @(posedge sys_clk);
            limit_case(lim, 100, lim);
            limit_case(lim + 5, 100, lim);
        end
        wr(speed_limit_pkg::ADDR_CTRL, 16'h01);
        alloc = 1'b0;
        limit_case(lim + 5, 100, lim);
        alloc = 1'b1;
        wr(speed_limit_pkg::ADDR_CTRL, 16'h09);
        wr(speed_limit_pkg::ADDR_IRQ_MASK, 16'h1);
        limit_case(0, 100, lim);
        wr(speed_limit_pkg::ADDR_IRQ_STAT, 16'h7);
        #1 chk(irq, 1'b0);
        limit_case(lim + 5, 100, lim);
        repeat (2) @(posedge sys_clk);
        #1 chk(irq, 1'b1);
        limit_case(0, 100, lim);
        wr(speed_limit_pkg::ADDR_IRQ_STAT, 16'h1);
        #1 chk(irq, 1'b0);
        rd(speed_limit_pkg::ADDR_IRQ_STAT);
        chk(rv[2:0], 3'h2);
        wr(speed_limit_pkg::ADDR_IRQ_MASK, 16'h2);
        #1 chk(irq, 1'b1);
        wr(speed_limit_pkg::ADDR_IRQ_MASK, 16'h0);
        #1 chk(irq, 1'b0);
        wr(speed_limit_pkg::ADDR_CTRL, 16'h38);
        #1 chk(preset_mode_active, 1'b0);
        wr(speed_limit_pkg::ADDR_RESTART, 16'h1);
        #1 chk(preset_mode_active, 1'b1);
        for (int i = 0; i < 2; i++) begin
            presets[i] = $urandom_range(10000);
            wr(4'(speed_limit_pkg::ADDR_PRESET1 + i), presets[i][15:0]);
        end
        wr(speed_limit_pkg::ADDR_PRESET3, 16'd12000);
        presets[2] = 10000;
        rd(speed_limit_pkg::ADDR_PRESET3);
        chk(rv, 16'h2710);
        for (int a = 0; a < 2; a++) begin
            wr(speed_limit_pkg::ADDR_CTRL, a ? 16'h3c : 16'h38);
            use_alt <= a[0];
            for (int r = 0; r < 2; r++) begin
                for (int c = 0; c < 4; c++) begin
                    preset_case(r[0], c[1:0]);
                end
            end
        end
        wr(speed_limit_pkg::ADDR_CTRL, 16'h48);
        use_alt <= 1'b0;
        wr(speed_limit_pkg::ADDR_RESTART, 16'h1);
        mode_switch_req <= 1'b1;
        preset_case(1'b0, 2'b00);
        chk(mode_switch_allowed, 1'b1);
        preset_case(1'b0, 2'b01);
        chk(mode_switch_allowed, 1'b0);
        give_verdict();
    end
endmodule
